// ### verilog/pic_defines.vh
`ifndef PIC_DEFINES_VH
`define PIC_DEFINES_VH
// register byte offsets
`define PIC_OFS_CTRL 8'h00
`define PIC_OFS_SETPOINT 8'h04
`define PIC_OFS_GAIN 8'h08
`define PIC_OFS_OFFSET 8'h0c
`define PIC_OFS_LIMIT_LO 8'h10
`define PIC_OFS_LIMIT_HI 8'h14
`define PIC_OFS_PGAIN 8'h18
`define PIC_OFS_ISPAN 8'h1c
`define PIC_OFS_MANUAL 8'h20
`define PIC_OFS_STATUS 8'h24
`define PIC_OFS_SCALED 8'h28
`define PIC_OFS_ACCUM 8'h2c
// control register fields
`define PIC_CTRL_DIR 0
`define PIC_CTRL_SETPOINT_EXT 1
`define PIC_CTRL_MANUAL_EXT 2
// status register fields
`define PIC_ST_OUT_LSB 0
`define PIC_ST_AUTO 16
`define PIC_ST_DIR 17
`define PIC_ST_HOLD 18
`define PIC_ST_BUSY 19
// value ranges
`define PIC_OUT_MIN 0
`define PIC_OUT_MAX 1000
`define PIC_LIMIT_LO -10000
`define PIC_LIMIT_HI 20000
`define PIC_GAIN_LO -1000
`define PIC_GAIN_HI 1000
`define PIC_OFFSET_LO -10000
`define PIC_OFFSET_HI 10000
`define PIC_PGAIN_MAX 9999
`define PIC_ISPAN_MIN 1
`define PIC_ISPAN_MAX 5999
`define PIC_ISPAN_OFF 13'h176f
`define PIC_FRAC_BITS 16
`define PIC_CENT 100
// reset values
`define PIC_RST_CTRL 3'h0
`define PIC_RST_GAIN 16'h0064
`define PIC_RST_LIMIT_HI 16'h4e20
`define PIC_RST_LIMIT_LO 16'hd8f0
`define PIC_RST_PGAIN 14'h0064
`define PIC_RST_ISPAN 13'h176f
// sampling
`define PIC_SAMPLE_MS 500
`define PIC_CLK_KHZ 200000
`define PIC_SAMPLE_CYCLES (`PIC_SAMPLE_MS * `PIC_CLK_KHZ)
// gain scale of 100 times two samples per second, divides kc*err per integral second
`define PIC_TS_CENT_DEN 200
`endif

// ### verilog/pic_loop_ctrl.v
// Summary of operation
// - mode input 1 automatic, 0 manual
// - reset input forces output zero, ignores mode
// - output confined to 0 through 1000
// - manual level accepted within 0 to 1000
// - manual mode drives output from manual level
// - entering automatic preloads accumulator with manual level
// - scaled value is raw times gain over 100 plus offset
// - scaled value clamped to upper bound
// - scaled value clamped to lower bound
// - bounds accepted within -10000 to 20000
// - scaled equal to setpoint leaves output unchanged
// - positive direction: above setpoint lowers output
// - negative direction: above setpoint raises output
// - direction frozen while control runs
// - zero proportional gain omits proportional term
// - maximum integral span omits integral term
// - one calculation per 500 ms sample
// - setpoint, manual level selectable from other block
// - direction setting positive or negative
`timescale 1ns/1ps
`include "pic_defines.vh"
module pic_loop_ctrl #(
  parameter SAMPLE_CYCLES = `PIC_SAMPLE_CYCLES
) (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0] wb_sel_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // control pins
  input wire auto_mode_i,
  input wire hold_reset_i,
  // values from other blocks
  input wire [15:0] process_value_i,
  input wire [15:0] setpoint_ext_i,
  input wire [15:0] manual_level_ext_i,
  // manipulated output
  output reg [15:0] control_output_o
);
  // calculation states
  localparam ST_IDLE = 2'd0;
  localparam ST_DIV = 2'd1;
  localparam ST_DONE = 2'd2;
  // last step of the serial divider
  localparam DIV_LAST = 6'd47;
  // integral span setting that switches the integral term off
  localparam [12:0] ISPAN_OFF = `PIC_ISPAN_OFF;
  // accumulator ceiling, full output with fraction bits
  localparam signed [31:0] ACC_CEIL = `PIC_OUT_MAX << `PIC_FRAC_BITS;

  // limit a value to lo..hi
  function signed [31:0] clamp;
    input signed [31:0] v;
    input signed [31:0] lo;
    input signed [31:0] hi;
    begin
      if (v > hi) begin
        clamp = hi;
      end else if (v < lo) begin
        clamp = lo;
      end else begin
        clamp = v;
      end
    end
  endfunction

  // limit a value to lo..hi and keep the low sixteen bits
  function [15:0] sat16;
    input signed [31:0] v;
    input signed [31:0] lo;
    input signed [31:0] hi;
    reg signed [31:0] c;
    begin
      c = clamp(v, lo, hi);
      sat16 = c[15:0];
    end
  endfunction

  // byte-lane merge of a sixteen bit register, sign extended
  function signed [31:0] merge16;
    input [15:0] old;
    input [31:0] dat;
    input [3:0] sel;
    reg [15:0] m;
    begin
      m = old;
      if (sel[0]) begin
        m[7:0] = dat[7:0];
      end
      if (sel[1]) begin
        m[15:8] = dat[15:8];
      end
      merge16 = {{16{m[15]}}, m};
    end
  endfunction

  // pin synchronisers
  reg auto_s1_reg;
  reg auto_s2_reg;
  reg hold_s1_reg;
  reg hold_s2_reg;
  always @(posedge clk_i) begin
    if (rst_i) begin
      auto_s1_reg <= 1'b0;
      auto_s2_reg <= 1'b0;
      hold_s1_reg <= 1'b0;
      hold_s2_reg <= 1'b0;
    end else begin
      auto_s1_reg <= auto_mode_i;
      auto_s2_reg <= auto_s1_reg;
      hold_s1_reg <= hold_reset_i;
      hold_s2_reg <= hold_s1_reg;
    end
  end

  // configuration registers
  reg [2:0] ctrl_reg;
  reg signed [15:0] setpoint_reg;
  reg signed [15:0] gain_reg;
  reg signed [15:0] offset_reg;
  reg signed [15:0] limit_lo_reg;
  reg signed [15:0] limit_hi_reg;
  reg signed [15:0] manual_level_reg;
  reg [13:0] pgain_reg;
  reg [12:0] ispan_reg;

  // bus request decode
  wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire bus_wr = bus_req & wb_we_i;
  wire bus_rd = bus_req & ~wb_we_i;

  // merged and range-limited write values
  wire [15:0] wr_setpoint = sat16(merge16(setpoint_reg, wb_dat_i, wb_sel_i),
                                  `PIC_LIMIT_LO, `PIC_LIMIT_HI);
  wire [15:0] wr_gain = sat16(merge16(gain_reg, wb_dat_i, wb_sel_i),
                              `PIC_GAIN_LO, `PIC_GAIN_HI);
  wire [15:0] wr_offset = sat16(merge16(offset_reg, wb_dat_i, wb_sel_i),
                                `PIC_OFFSET_LO, `PIC_OFFSET_HI);
  wire [15:0] wr_limit_lo = sat16(merge16(limit_lo_reg, wb_dat_i, wb_sel_i),
                                  `PIC_LIMIT_LO, `PIC_LIMIT_HI);
  wire [15:0] wr_limit_hi = sat16(merge16(limit_hi_reg, wb_dat_i, wb_sel_i),
                                  `PIC_LIMIT_LO, `PIC_LIMIT_HI);
  wire [15:0] wr_pgain = sat16(merge16({2'b00, pgain_reg}, wb_dat_i, wb_sel_i),
                               0, `PIC_PGAIN_MAX);
  wire [15:0] wr_ispan = sat16(merge16({3'b000, ispan_reg}, wb_dat_i, wb_sel_i),
                               `PIC_ISPAN_MIN, `PIC_ISPAN_MAX);
  wire [15:0] wr_manual = sat16(merge16(manual_level_reg, wb_dat_i, wb_sel_i),
                                `PIC_OUT_MIN, `PIC_OUT_MAX);

  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= `PIC_RST_CTRL;
      setpoint_reg <= 16'h0000;
      gain_reg <= `PIC_RST_GAIN;
      offset_reg <= 16'h0000;
      limit_lo_reg <= `PIC_RST_LIMIT_LO;
      limit_hi_reg <= `PIC_RST_LIMIT_HI;
      pgain_reg <= `PIC_RST_PGAIN;
      ispan_reg <= `PIC_RST_ISPAN;
      manual_level_reg <= 16'h0000;
    end else if (bus_wr) begin
      case (wb_adr_i)
        `PIC_OFS_CTRL: begin
          if (wb_sel_i[0]) begin
            ctrl_reg <= wb_dat_i[2:0];
          end
        end
        `PIC_OFS_SETPOINT: begin
          setpoint_reg <= wr_setpoint;
        end
        `PIC_OFS_GAIN: begin
          gain_reg <= wr_gain;
        end
        `PIC_OFS_OFFSET: begin
          offset_reg <= wr_offset;
        end
        `PIC_OFS_LIMIT_LO: begin
          limit_lo_reg <= wr_limit_lo;
        end
        `PIC_OFS_LIMIT_HI: begin
          limit_hi_reg <= wr_limit_hi;
        end
        `PIC_OFS_PGAIN: begin
          pgain_reg <= wr_pgain[13:0];
        end
        `PIC_OFS_ISPAN: begin
          ispan_reg <= wr_ispan[12:0];
        end
        `PIC_OFS_MANUAL: begin
          manual_level_reg <= wr_manual;
        end
        default: begin
        end
      endcase
    end
  end

  // effective setpoint and manual level
  wire signed [31:0] setpoint_ext_wide = $signed({{16{setpoint_ext_i[15]}}, setpoint_ext_i});
  wire signed [31:0] manual_ext_wide = $signed({{16{manual_level_ext_i[15]}},
                                                manual_level_ext_i});
  wire signed [31:0] setpoint_eff = ctrl_reg[`PIC_CTRL_SETPOINT_EXT] ?
    clamp(setpoint_ext_wide, `PIC_LIMIT_LO, `PIC_LIMIT_HI) :
    {{16{setpoint_reg[15]}}, setpoint_reg};
  wire signed [31:0] manual_eff = ctrl_reg[`PIC_CTRL_MANUAL_EXT] ?
    clamp(manual_ext_wide, `PIC_OUT_MIN, `PIC_OUT_MAX) :
    {{16{manual_level_reg[15]}}, manual_level_reg};

  // scaled and limited process value
  wire signed [31:0] proc_prod = $signed(process_value_i) * gain_reg;
  wire signed [31:0] proc_lin = proc_prod / 32'sd100 + offset_reg;
  wire signed [31:0] proc_scaled = clamp(proc_lin, limit_lo_reg, limit_hi_reg);

  // sample tick
  reg [31:0] tick_cnt_reg;
  wire tick = (tick_cnt_reg == SAMPLE_CYCLES - 1);
  always @(posedge clk_i) begin
    if (rst_i || tick)
      tick_cnt_reg <= 32'h0;
    else
      tick_cnt_reg <= tick_cnt_reg + 32'h1;
  end

  // mode tracking
  reg auto_reg;
  reg dir_reg;
  wire auto_now = auto_s2_reg & ~hold_s2_reg;
  wire entering = auto_now & ~auto_reg;

  // error with direction applied
  wire signed [31:0] err_raw = setpoint_eff - proc_scaled;
  wire signed [31:0] err_dir = dir_reg ? -err_raw : err_raw;
  wire signed [31:0] p_prod = $signed({18'h0, pgain_reg}) * err_dir;
  wire integral_off = (ispan_reg == ISPAN_OFF) || (pgain_reg == 14'h0);

  // calculation state
  reg [1:0] state_reg;
  reg signed [31:0] accum_reg;
  reg signed [31:0] p_term_reg;
  reg [47:0] quot_reg;
  reg [21:0] rem_reg;
  reg [5:0] bit_cnt_reg;
  reg neg_reg;

  // serial divider datapath
  wire [31:0] den = `PIC_TS_CENT_DEN * {19'h0, ispan_reg};
  wire [47:0] p_mag = p_prod[31] ? {16'h0, -p_prod} : {16'h0, p_prod};
  wire [22:0] rem_shift = {rem_reg, quot_reg[47]};
  wire rem_ge = ({9'h0, rem_shift} >= den);
  // a quotient beyond full scale would wrap the accumulator, so it saturates
  wire [31:0] quot_sat = (quot_reg > {16'h0, ACC_CEIL}) ? ACC_CEIL : quot_reg[31:0];
  wire signed [31:0] inc = neg_reg ? -$signed(quot_sat) : $signed(quot_sat);
  wire signed [31:0] accum_new = clamp(accum_reg + inc, 0, ACC_CEIL);
  wire signed [31:0] out_sum = clamp((accum_new >>> `PIC_FRAC_BITS) + p_term_reg,
                                     `PIC_OUT_MIN, `PIC_OUT_MAX);

  always @(posedge clk_i) begin
    if (rst_i || hold_s2_reg) begin
      auto_reg <= 1'b0;
      dir_reg <= 1'b0;
      state_reg <= ST_IDLE;
      accum_reg <= 32'sh0;
      p_term_reg <= 32'sh0;
      quot_reg <= 48'h0;
      rem_reg <= 22'h0;
      bit_cnt_reg <= 6'h0;
      neg_reg <= 1'b0;
      control_output_o <= 16'h0;
    end else begin
      auto_reg <= auto_now;
      if (!auto_now) begin
        state_reg <= ST_IDLE;
        dir_reg <= ctrl_reg[`PIC_CTRL_DIR];
        control_output_o <= manual_eff[15:0];
      end else if (entering) begin
        accum_reg <= manual_eff << `PIC_FRAC_BITS;
        dir_reg <= ctrl_reg[`PIC_CTRL_DIR];
        state_reg <= ST_IDLE;
        control_output_o <= manual_eff[15:0];
      end else begin
        case (state_reg)
          ST_IDLE: begin
            if (tick && err_raw != 32'sh0) begin
              p_term_reg <= (pgain_reg == 14'h0) ? 32'sh0 :
                            p_prod / 32'sd100;
              neg_reg <= p_prod[31];
              rem_reg <= 22'h0;
              bit_cnt_reg <= 6'h0;
              if (integral_off) begin
                quot_reg <= 48'h0;
                state_reg <= ST_DONE;
              end else begin
                quot_reg <= p_mag << `PIC_FRAC_BITS;
                state_reg <= ST_DIV;
              end
            end
          end
          ST_DIV: begin
            rem_reg <= rem_ge ? rem_shift[21:0] - den[21:0] : rem_shift[21:0];
            quot_reg <= {quot_reg[46:0], rem_ge};
            bit_cnt_reg <= bit_cnt_reg + 6'h1;
            if (bit_cnt_reg == DIV_LAST) begin
              state_reg <= ST_DONE;
            end
          end
          ST_DONE: begin
            accum_reg <= accum_new;
            control_output_o <= out_sum[15:0];
            state_reg <= ST_IDLE;
          end
          default: begin
            state_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // bus answer and read data
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_rd) begin
        case (wb_adr_i)
          `PIC_OFS_CTRL: begin
            wb_dat_o <= {29'h0, ctrl_reg};
          end
          `PIC_OFS_SETPOINT: begin
            wb_dat_o <= {{16{setpoint_reg[15]}}, setpoint_reg};
          end
          `PIC_OFS_GAIN: begin
            wb_dat_o <= {{16{gain_reg[15]}}, gain_reg};
          end
          `PIC_OFS_OFFSET: begin
            wb_dat_o <= {{16{offset_reg[15]}}, offset_reg};
          end
          `PIC_OFS_LIMIT_LO: begin
            wb_dat_o <= {{16{limit_lo_reg[15]}}, limit_lo_reg};
          end
          `PIC_OFS_LIMIT_HI: begin
            wb_dat_o <= {{16{limit_hi_reg[15]}}, limit_hi_reg};
          end
          `PIC_OFS_PGAIN: begin
            wb_dat_o <= {18'h0, pgain_reg};
          end
          `PIC_OFS_ISPAN: begin
            wb_dat_o <= {19'h0, ispan_reg};
          end
          `PIC_OFS_MANUAL: begin
            wb_dat_o <= {{16{manual_level_reg[15]}}, manual_level_reg};
          end
          `PIC_OFS_STATUS: begin
            wb_dat_o <= {12'h0, (state_reg != ST_IDLE), hold_s2_reg, dir_reg,
                         auto_reg, control_output_o};
          end
          `PIC_OFS_SCALED: begin
            wb_dat_o <= proc_scaled;
          end
          `PIC_OFS_ACCUM: begin
            wb_dat_o <= accum_reg;
          end
          default: begin
            wb_dat_o <= 32'h0;
          end
        endcase
      end
    end
  end
endmodule // pic_loop_ctrl

// ### testbench/pic_loop_ctrl_asserts.sv
`timescale 1ns/1ps
module pic_loop_ctrl_asserts #(
  parameter SAMPLE_CYCLES = 200
) (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  // pins and values
  input wire auto_mode_i,
  input wire hold_reset_i,
  input wire [15:0] process_value_i,
  input wire [15:0] setpoint_ext_i,
  input wire [15:0] manual_level_ext_i,
  input wire [15:0] control_output_o
);
  // phase within the sample period, counted from reset release
  int ph;
  always @(posedge clk_i) begin
    ph <= (rst_i || ph >= SAMPLE_CYCLES - 1) ? 0 : ph + 1;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered in one cycle");
  a_unmapped_zero: assert property (wb_cyc_i && wb_stb_i && !wb_we_i && wb_adr_i == 8'h30
    && !wb_ack_o |=> wb_dat_o == 32'h0) else $error("unmapped read not zero");
  a_out_range: assert property (control_output_o <= 16'd1000)
    else $error("output above range");
  a_hold_zero: assert property (hold_reset_i [*5] |-> control_output_o == 16'h0)
    else $error("output not zero in hold");
  a_manual_hold: assert property (
    (!auto_mode_i && !hold_reset_i && !wb_cyc_i) [*7] |-> $stable(control_output_o))
    else $error("manual output moved");
  a_calc_phase: assert property (
    $changed(control_output_o) && auto_mode_i && $past(auto_mode_i, 6) && !hold_reset_i
    |-> ph < 64 || ph > SAMPLE_CYCLES - 8) else $error("output changed off the tick");
  c_write: cover property (wb_ack_o && wb_we_i);
  c_auto: cover property ($rose(auto_mode_i));
  c_hold: cover property (hold_reset_i [*5]);
endmodule // pic_loop_ctrl_asserts
bind pic_loop_ctrl pic_loop_ctrl_asserts #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .auto_mode_i(auto_mode_i),
  .hold_reset_i(hold_reset_i), .process_value_i(process_value_i),
  .setpoint_ext_i(setpoint_ext_i), .manual_level_ext_i(manual_level_ext_i),
  .control_output_o(control_output_o));

// ### testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, auto = 1'b0, hold = 1'b0;
  logic [7:0] adr = 8'h0;
  logic [31:0] dat = 32'h0;
  logic [15:0] pv = 16'd100, sp_ext = 16'd0, mq_ext = 16'd700;
  wire [31:0] rdat;
  wire ack;
  wire [15:0] outv;
  int err_total = 0, compares = 0;
  always #2.5 clk_i = ~clk_i;
  pic_loop_ctrl #(.SAMPLE_CYCLES(200)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'hf), .wb_dat_o(rdat), .wb_ack_o(ack),
    .auto_mode_i(auto), .hold_reset_i(hold), .process_value_i(pv),
    .setpoint_ext_i(sp_ext), .manual_level_ext_i(mq_ext), .control_output_o(outv));
  task automatic tally_and_finish();
    $display("mismatches %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  // one classic cycle, held until ack is sampled
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
      output logic [31:0] q);
    int n;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_i);
      if (ack === 1'b1) break;
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
    if (n == 20) begin
      err_total++;
      tally_and_finish();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(a, 1'b0, 32'h0, q);
    chk($sformatf("reg %h", a), e, q);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic out(input logic [15:0] e);
    @(negedge clk_i);
    chk("output", {16'h0, e}, {16'h0, outv});
    @(posedge clk_i);
  endtask
  // waits for the next output update, then compares it
  task automatic wait_out(input logic [15:0] e);
    logic [15:0] o;
    int n;
    @(negedge clk_i);
    o = outv;
    for (n = 0; n < 400 && outv === o; n++) @(negedge clk_i);
    if (n == 400) begin
      err_total++;
      tally_and_finish();
    end
    out(e);
  endtask
  initial begin
    idle(10);
    rst_i <= 1'b0;
    idle(1);
    rd(8'h08, 32'h64);
    rd(8'h14, 32'h4e20);
    rd(8'h10, 32'hffffd8f0);
    rd(8'h1c, 32'h176f);
    rd(8'h30, 32'h0);
    wr(8'h20, 32'd1500);
    rd(8'h20, 32'd1000);
    wr(8'h14, 32'd30000);
    rd(8'h14, 32'd20000);
    wr(8'h20, 32'd400);
    idle(8);
    out(16'd400);
    wr(8'h08, 32'd200);
    wr(8'h0c, 32'd50);
    idle(210);
    rd(8'h28, 32'd250);
    wr(8'h14, 32'd200);
    idle(210);
    rd(8'h28, 32'd200);
    wr(8'h14, 32'd20000);
    wr(8'h10, 32'd300);
    idle(210);
    rd(8'h28, 32'd300);
    wr(8'h10, 32'hffffd8f0);
    wr(8'h04, 32'd250);
    auto <= 1'b1;
    idle(8);
    rd(8'h2c, 32'h01900000);
    idle(250);
    out(16'd400);
    wr(8'h04, 32'd350);
    wait_out(16'd500);
    wr(8'h04, 32'd150);
    wait_out(16'd300);
    auto <= 1'b0;
    wr(8'h04, 32'd250);
    wr(8'h00, 32'h1);
    auto <= 1'b1;
    idle(8);
    wr(8'h00, 32'h0);
    wr(8'h04, 32'd150);
    wait_out(16'd500);
    wr(8'h18, 32'h0);
    wait_out(16'd400);
    auto <= 1'b0;
    wr(8'h18, 32'd100);
    wr(8'h1c, 32'd1);
    sp_ext <= 16'd250;
    wr(8'h00, 32'h2);
    auto <= 1'b1;
    idle(8);
    sp_ext <= 16'd350;
    wait_out(16'd550);
    hold <= 1'b1;
    idle(6);
    auto <= 1'b0;
    idle(6);
    out(16'h0);
    rd(8'h24, 32'h00040000);
    hold <= 1'b0;
    wr(8'h00, 32'h4);
    idle(8);
    out(16'd700);
    tally_and_finish();
  end
endmodule // tb_top
